// ==== verilog/quad_dac_ctrl.sv ====
// Pin-strap, load-strobe and serial-port control of a four-channel converter.
// Assumes an APB master on pclk; all pins are asynchronous to pclk.
//
// Behaviour
// - Gain strap is sampled after every reset, low gives gain 1 and high gain 2.
// - Later changes on the gain and divider straps have no effect.
// - At reset all four codes go to zero scale, or midscale if the level select is high.
// - Divider strap is sampled after every reset, high halves the reference.
// - A falling load strobe updates together every channel set for synchronous mode.
// - With the load strobe tied low, channels not in synchronous mode still update.
// - Low frame select delimits each serial frame, its rising edge ends it.
// - The input shift register shifts only while frame select is low.
// - One serial input bit is captured on each falling serial clock edge.
// - Outside fault mode, serial output is released whenever frame select is high.
// - Shift register contents leave on the edge chosen by the output edge bit.
// - After reset the shared pin acts as serial output, not as fault output.
// - In fault mode the shared pin is an active-low open-drain fault signal.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "quad_dac_params.svh"

module quad_dac_ctrl
	import quad_dac_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic                     irq,
	input  wire logic                gain_strap,
	input  wire logic                reset_level_select,
	input  wire logic                ref_divide_strap,
	input  wire logic                load_strobe_n,
	input  wire logic                frame_sel_n,
	input  wire logic                serial_clk,
	input  wire logic                serial_in,
	input  wire logic                ref_alarm,
	output logic                     serial_out_or_fault_o,
	output logic                     serial_out_or_fault_oe,
	output logic                     gain_x2,
	output logic                     ref_div2,
	output logic [3:0][`CODE_W-1:0]  dac_code
);
	logic [6:0]              pins_s;
	logic                    gain_s, rst_s, ref_divide_strap_s, load_strobe_n_s, fs_s, sclk_s, sdi_s, ref_s;
	logic [31:0]             ctrl_q, mask_q;
	logic [`ST_W-1:0]        status_q, st_set;
	logic [`FRAME_W-1:0]     shift_q, rx_q;
	logic [4:0]              count_q;
	logic                    sdo_q, sclk_rise, sclk_fall;
	logic [1:0]              settle_q;
	logic                    strap_done_q, strap_take, rst_lvl_q;
	logic                    load_strobe_n_prev_q, ref_prev_q, load_strobe_n_fall;
	frame_state_e            frame_q;
	logic                    frame_end, word_ok, frame_bad;
	logic [1:0]              wch;
	code_t                   pend_q [4];
	logic                    wr_en, rd_en, mapped;
	logic [31:0]             rd_mux;

	pin_sync #(.W(7), .RST(`PIN_SYNC_RST)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({frame_sel_n, load_strobe_n, gain_strap, reset_level_select,
		         ref_divide_strap, serial_clk, {serial_in}}),
		.q     (pins_s)
	);

	assign {fs_s, load_strobe_n_s, gain_s, rst_s, ref_divide_strap_s, sclk_s, sdi_s} = pins_s;

	pin_sync #(.W(1), .RST(1'b0)) u_sync_ref (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (ref_alarm),
		.q     (ref_s)
	);

	// Straps are taken once the synchronisers hold real pin levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q     <= '0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			settle_q     <= settle_q + 2'd1;
			strap_done_q <= (settle_q == `STRAP_SETTLE);
		end
	end

	assign strap_take = !strap_done_q && (settle_q == `STRAP_SETTLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_x2   <= 1'b0;
			ref_div2  <= 1'b0;
			rst_lvl_q <= 1'b0;
		end else if (strap_take) begin
			gain_x2   <= gain_s;
			ref_div2  <= ref_divide_strap_s;
			rst_lvl_q <= rst_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			frame_q <= FRM_IDLE;
		else begin
			case (frame_q)
				FRM_IDLE:   if (!fs_s) frame_q <= FRM_ACTIVE;
				FRM_ACTIVE: if (fs_s) frame_q <= FRM_IDLE;
				default:    frame_q <= FRM_IDLE;
			endcase
		end
	end

	assign frame_end = (frame_q == FRM_ACTIVE) && fs_s;
	assign word_ok   = frame_end && (count_q == `FRAME_BITS);
	assign frame_bad = frame_end && (count_q != `FRAME_BITS);
	assign wch       = shift_q[`CH_MSB:`CH_LSB];

	serial_shifter u_shift (
		.clk       (pclk),
		.rst_n     (presetn),
		.enable    (frame_q == FRM_ACTIVE && !fs_s),
		.sclk_s    (sclk_s),
		.sdi_s     (sdi_s),
		.edge_sel  (ctrl_q[`CTRL_EDGE]),
		.shift_q   (shift_q),
		.count_q   (count_q),
		.sdo_q     (sdo_q),
		.sclk_rise (sclk_rise),
		.sclk_fall (sclk_fall)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_q <= '0;
		else if (word_ok)
			rx_q <= shift_q;
	end

	// No false edge if the strobe is low from reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_strobe_n_prev_q <= 1'b0;
			ref_prev_q  <= 1'b0;
		end else begin
			load_strobe_n_prev_q <= load_strobe_n_s;
			ref_prev_q  <= ref_s;
		end
	end

	assign load_strobe_n_fall = load_strobe_n_prev_q && !load_strobe_n_s;

	// Pending codes for synchronous channels and live output codes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_code <= '0;
			for (int i = 0; i < 4; i++)
				pend_q[i] <= `CODE_ZERO;
		end else if (strap_take) begin
			for (int i = 0; i < 4; i++) begin
				dac_code[i] <= rst_s ? `CODE_MID : `CODE_ZERO;
				pend_q[i]   <= rst_s ? `CODE_MID : `CODE_ZERO;
			end
		end else begin
			if (load_strobe_n_fall) begin
				for (int i = 0; i < 4; i++)
					if (ctrl_q[`CTRL_SYNC_LSB+i])
						dac_code[i] <= pend_q[i];
			end
			if (word_ok) begin
				pend_q[wch] <= shift_q[`CODE_W-1:0];
				if (!ctrl_q[`CTRL_SYNC_LSB+wch])
					dac_code[wch] <= shift_q[`CODE_W-1:0];
			end
		end
	end

	// Wrong bit count stands in for a frame check error
	assign st_set = {ref_s & ~ref_prev_q, frame_bad, load_strobe_n_fall, word_ok};

	always_comb begin
		if (ctrl_q[`CTRL_ALARM]) begin
			serial_out_or_fault_o  = 1'b0;
			serial_out_or_fault_oe = status_q[`ST_CRC] | status_q[`ST_REF];
		end else begin
			serial_out_or_fault_o  = sdo_q;
			serial_out_or_fault_oe = !fs_s;
		end
	end

	// APB slave, zero wait states; read data latched in the setup cycle
	assign wr_en  = psel && penable && pwrite;
	assign rd_en  = psel && !penable;
	assign pready = 1'b1;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFF_CODE3);

	always_comb begin
		rd_mux = '0;
		case (paddr)
			`OFF_CTRL:   rd_mux = ctrl_q;
			`OFF_STATUS: rd_mux[`ST_W-1:0] = status_q;
			`OFF_MASK:   rd_mux = mask_q;
			`OFF_STRAP:  rd_mux[3:0] = {strap_done_q, rst_lvl_q, ref_div2, gain_x2};
			`OFF_RXWORD: rd_mux[`FRAME_W-1:0] = rx_q;
			default: begin
				if (mapped && paddr >= `OFF_CODE0)
					rd_mux[`CODE_W-1:0] = dac_code[2'(paddr[4:2] - 3'd5)];
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (rd_en) begin
			prdata  <= rd_mux;
			pslverr <= !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CTRL_RESET;
			mask_q <= '0;
		end else if (wr_en && paddr == `OFF_CTRL) begin
			ctrl_q <= pwdata & `CTRL_WMASK;
		end else if (wr_en && paddr == `OFF_MASK) begin
			mask_q <= pwdata & `MASK_WMASK;
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_q <= '0;
		else if (wr_en && paddr == `OFF_STATUS)
			status_q <= (status_q & ~pwdata[`ST_W-1:0]) | st_set;
		else
			status_q <= status_q | st_set;
	end

	assign irq = |(status_q & mask_q[`ST_W-1:0]);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_gain; $rose(strap_done_q) |-> gain_x2 == $past(gain_s); endproperty
	a_gain: assert property (p_gain) else $error("gain strap not taken");

	property p_hold; strap_done_q && $past(strap_done_q) |-> $stable(gain_x2) && $stable(ref_div2);
	endproperty
	a_hold: assert property (p_hold) else $error("strap result changed");

	property p_level; $rose(strap_done_q)
		|-> dac_code[3] == ($past(rst_s) ? `CODE_MID : `CODE_ZERO); endproperty
	a_level: assert property (p_level) else $error("wrong reset level");

	property p_ref_divide_strap; $rose(strap_done_q) |-> ref_div2 == $past(ref_divide_strap_s); endproperty
	a_ref_divide_strap: assert property (p_ref_divide_strap) else $error("divider strap not taken");

	property p_load; strap_done_q && load_strobe_n_fall && ctrl_q[`CTRL_SYNC_LSB+1]
		&& !(word_ok && wch == 2'd1) |=> dac_code[1] == $past(pend_q[1]); endproperty
	a_load: assert property (p_load) else $error("sync channel not loaded");

	property p_async; strap_done_q && word_ok && !ctrl_q[`CTRL_SYNC_LSB + wch]
		|=> dac_code[$past(wch)] == $past(shift_q[`CODE_W-1:0]); endproperty
	a_async: assert property (p_async) else $error("async channel not updated");

	property p_frame; word_ok |=> rx_q == $past(shift_q) ##1 frame_q == FRM_IDLE || !fs_s;
	endproperty
	a_frame: assert property (p_frame) else $error("frame word lost");

	property p_noshift; fs_s |=> $stable(shift_q); endproperty
	a_noshift: assert property (p_noshift) else $error("shift outside frame");

	property p_capture; frame_q == FRM_ACTIVE && !fs_s && sclk_fall |=> shift_q[0] == $past(sdi_s);
	endproperty
	a_capture: assert property (p_capture) else $error("bit not captured");

	property p_hiz; fs_s && !ctrl_q[`CTRL_ALARM] |-> !serial_out_or_fault_oe; endproperty
	a_hiz: assert property (p_hiz) else $error("output driven while deselected");

	property p_edge; !fs_s && frame_q == FRM_ACTIVE && !ctrl_q[`CTRL_EDGE] && sclk_rise
		|=> sdo_q == $past(shift_q[`FRAME_W-1]); endproperty
	a_edge: assert property (p_edge) else $error("output not shifted on rise");

	property p_default; $rose(strap_done_q) |-> !ctrl_q[`CTRL_ALARM]; endproperty
	a_default: assert property (p_default) else $error("fault mode after reset");

	property p_fault; ctrl_q[`CTRL_ALARM] && (status_q[`ST_CRC] || status_q[`ST_REF])
		|-> serial_out_or_fault_oe && !serial_out_or_fault_o; endproperty
	a_fault: assert property (p_fault) else $error("fault not driven low");

	c_word: cover property (word_ok);
	c_load: cover property (load_strobe_n_fall && ctrl_q[`CTRL_SYNC_LSB+1]);
	c_fault: cover property (ctrl_q[`CTRL_ALARM] && serial_out_or_fault_oe);
endmodule

`default_nettype wire

// ==== verilog/quad_dac_params.svh ====
// Constants for the quad converter pin-strap and serial-port block.
// Included by the package and by every design file that needs a number.
`ifndef QUAD_DAC_PARAMS_SVH
`define QUAD_DAC_PARAMS_SVH

// APB register byte offsets
`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_MASK       8'h08
`define OFF_STRAP      8'h0c
`define OFF_RXWORD     8'h10
`define OFF_CODE0      8'h14
`define OFF_CODE3      8'h20

// Control register fields
`define CTRL_ALARM     0
`define CTRL_EDGE      1
`define CTRL_SYNC_LSB  4
`define CTRL_RESET     32'h0000_0000

// Writable bits of the control and mask registers
`define CTRL_WMASK     32'h0000_00f3
`define MASK_WMASK     32'h0000_000f

// Synchroniser reset: frame select idles high; strobe stage low so no false fall
`define PIN_SYNC_RST   7'h40

// Status and mask bits
`define ST_FRAME       0
`define ST_LOAD        1
`define ST_CRC         2
`define ST_REF         3
`define ST_W           4

// Strap readback bits
`define SP_GAIN        0
`define SP_REF_DIVIDE_STRAP      1
`define SP_RSTLVL      2
`define SP_DONE        3

// Serial frame layout
`define FRAME_W        24
`define FRAME_BITS     5'd24
`define CH_LSB         16
`define CH_MSB         17
`define CODE_W         16
`define CODE_ZERO      16'h0000
`define CODE_MID       16'h8000

// Cycles after reset release before straps are taken (two sync stages plus one)
`define STRAP_SETTLE   2'd3

`endif

// ==== verilog/quad_dac_pkg.sv ====
// Types shared by the quad converter control block.
// Assumes quad_dac_params.svh is on the include path.
`include "quad_dac_params.svh"

package quad_dac_pkg;
	typedef logic [`CODE_W-1:0] code_t;
	typedef enum logic [0:0] {
		FRM_IDLE   = 1'b0,
		FRM_ACTIVE = 1'b1
	} frame_state_e;
endpackage

// ==== verilog/pin_sync.sv ====
// Two-flop synchroniser for a group of pins.
// Assumes each bit is an independent level from outside the pclk domain.
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST;
			q      <= RST;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

`default_nettype wire

// ==== verilog/serial_shifter.sv ====
// Serial shift engine: finds serial clock edges and shifts data in and out.
// Assumes sclk, sdi are already synchronised to clk.
`timescale 1ns/1ns
`default_nettype none
`include "quad_dac_params.svh"

module serial_shifter
	import quad_dac_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                enable,
	input  wire logic                sclk_s,
	input  wire logic                sdi_s,
	input  wire logic                edge_sel,
	output logic [`FRAME_W-1:0]      shift_q,
	output logic [4:0]               count_q,
	output logic                     sdo_q,
	output logic                     sclk_rise,
	output logic                     sclk_fall
);
	logic sclk_prev_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sclk_prev_q <= 1'b0;
		else
			sclk_prev_q <= sclk_s;
	end

	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;

	// Bits enter on the falling edge only inside the frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
			count_q <= '0;
		end else if (!enable) begin
			count_q <= '0;
		end else if (sclk_fall) begin
			shift_q <= {shift_q[`FRAME_W-2:0], sdi_s};
			if (count_q != 5'h1f)
				count_q <= count_q + 5'h01;
		end
	end

	// Output changes on the edge picked by edge_sel (0 rising, 1 falling)
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sdo_q <= 1'b0;
		else if (!enable)
			sdo_q <= shift_q[`FRAME_W-1];
		else if (edge_sel ? sclk_fall : sclk_rise)
			sdo_q <= shift_q[`FRAME_W-1];
	end
endmodule

`default_nettype wire

// ==== testbench/serial_host_model.sv ====
// Host-side serial master for the quad converter control block.
// Assumes the bench calls send and stray; the link clock idles low between frames.
`timescale 1ns/1ns
`default_nettype none

module serial_host_model (
	output logic      frame_sel_n,
	output logic      serial_clk,
	output logic      serial_in,
	input  wire logic pin_o,
	input  wire logic pin_oe
);
	logic [47:0] pre_rise;
	logic [47:0] pre_fall;

	initial begin
		frame_sel_n = 1'b1;
		serial_clk = 1'b0;
		serial_in = 1'b0;
	end

	// Clock edges while deselected must not be counted
	task automatic stray(input int n);
		#7;
		repeat (n) begin
			#160 serial_clk = 1'b1;
			#160 serial_clk = 1'b0;
		end
	endtask

	// Samples sit half a link period after each edge, well past the sync delay
	task automatic send(input logic [47:0] bits, input int n);
		#7;
		frame_sel_n = 1'b0;
		#160;
		for (int i = 0; i < n; i++) begin
			serial_in = bits[n-1-i];
			#80 pre_rise[i] = pin_oe ? pin_o : 1'bz;
			serial_clk = 1'b1;
			#160 pre_fall[i] = pin_oe ? pin_o : 1'bz;
			serial_clk = 1'b0;
			#80;
		end
		// Released line must not keep the last bit
		serial_in = ~serial_in;
		#80 frame_sel_n = 1'b1;
		#160;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_quad_dac_pin_strap_and_serial_port.sv ====
// Self-checking bench for the quad converter control block.
// Assumes the design sources and quad_dac_params.svh are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "quad_dac_params.svh"

module tb_quad_dac_pin_strap_and_serial_port
	import quad_dac_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic gain_strap, reset_level_select, ref_divide_strap, load_strobe_n, ref_alarm;
	logic frame_sel_n, serial_clk, serial_in, pin_o, pin_oe, gain_x2, ref_div2;
	logic [7:0]              paddr;
	logic [31:0]             pwdata, prdata, rd;
	logic [3:0][`CODE_W-1:0] dac_code;
	int                      error_cnt;
	int                      check_count;

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	quad_dac_ctrl quad_dac_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.gain_strap(gain_strap), .reset_level_select(reset_level_select),
		.ref_divide_strap(ref_divide_strap), .load_strobe_n(load_strobe_n),
		.frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_in(serial_in),
		.ref_alarm(ref_alarm), .serial_out_or_fault_o(pin_o),
		.serial_out_or_fault_oe(pin_oe), .gain_x2(gain_x2), .ref_div2(ref_div2),
		.dac_code(dac_code));

	serial_host_model serial_host_model_inst (.frame_sel_n(frame_sel_n),
		.serial_clk(serial_clk), .serial_in(serial_in), .pin_o(pin_o), .pin_oe(pin_oe));

	task automatic conclude();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			error_cnt++;
			conclude();
		end
	endtask

	function automatic logic [47:0] word(input logic [1:0] ch, input logic [15:0] code);
		return {30'h0, ch, code};
	endfunction

	task automatic frame(input logic [1:0] ch, input logic [15:0] code, input int n);
		serial_host_model_inst.send(word(ch, code), n);
		idle(6);
	endtask

	// Straps stay still for the whole reset, then the gain and divider straps flip once it is over
	task automatic t_straps(input logic g, input logic l, input logic r);
		@(posedge pclk);
		gain_strap <= g;
		reset_level_select <= l;
		ref_divide_strap <= r;
		presetn <= 1'b0;
		idle(16);
		presetn <= 1'b1;
		idle(8);
		check("gain_x2", gain_x2, g);
		check("ref_div2", ref_div2, r);
		for (int c = 0; c < 4; c++) begin
			check("code", dac_code[c], l ? `CODE_MID : `CODE_ZERO);
		end
		apb(1'b0, `OFF_STRAP, 32'h0);
		check("strap", rd, {28'h0, 1'b1, l, r, g});
		apb(1'b0, `OFF_CTRL, 32'h0);
		check("ctrl", rd, `CTRL_RESET);
		check("oe idle", pin_oe, 1'b0);
		gain_strap <= ~g;
		ref_divide_strap <= ~r;
		idle(8);
		check("gain_x2 held", gain_x2, g);
		check("ref_div2 held", ref_div2, r);
	endtask

	task automatic t_async();
		serial_host_model_inst.stray(6);
		frame(2'd2, 16'h1234, 24);
		check("code2", dac_code[2], 32'h1234);
		apb(1'b0, `OFF_RXWORD, 32'h0);
		check("rxword", rd, 32'h0002_1234);
		apb(1'b0, `OFF_STATUS, 32'h0);
		check("status", rd, 32'h1);
	endtask

	task automatic t_sync();
		apb(1'b1, `OFF_CTRL, 32'h20);
		frame(2'd1, 16'hbeef, 24);
		frame(2'd3, 16'h0333, 24);
		check("code1 waits", dac_code[1], 32'h0);
		check("code3", dac_code[3], 32'h0333);
		load_strobe_n <= 1'b0;
		idle(6);
		check("code1 loaded", dac_code[1], 32'hbeef);
		apb(1'b0, `OFF_STATUS, 32'h0);
		check("status load", rd[1], 1'b1);
		apb(1'b1, `OFF_CTRL, 32'h0);
		frame(2'd1, 16'h4321, 24);
		check("code1 strobe low", dac_code[1], 32'h4321);
		load_strobe_n <= 1'b1;
	endtask

	task automatic t_fault();
		apb(1'b1, `OFF_STATUS, 32'hf);
		apb(1'b1, `OFF_MASK, 32'h4);
		frame(2'd0, 16'h5555, 23);
		check("code0 kept", dac_code[0], 32'h0);
		apb(1'b0, `OFF_STATUS, 32'h0);
		check("status crc", rd[2], 1'b1);
		check("irq", irq, 1'b1);
		check("oe data mode", pin_oe, 1'b0);
		apb(1'b1, `OFF_CTRL, 32'h1);
		idle(2);
		check("fault oe", pin_oe, 1'b1);
		check("fault low", pin_o, 1'b0);
		apb(1'b1, `OFF_MASK, 32'h0);
		idle(2);
		check("irq masked", irq, 1'b0);
		apb(1'b1, `OFF_STATUS, 32'h4);
		idle(2);
		check("fault off", pin_oe, 1'b0);
		ref_alarm <= 1'b1;
		idle(6);
		check("fault ref", pin_oe, 1'b1);
		ref_alarm <= 1'b0;
		apb(1'b1, `OFF_STATUS, 32'h8);
		idle(2);
		check("fault ref off", pin_oe, 1'b0);
		apb(1'b1, `OFF_CTRL, 32'h0);
	endtask

	// An overlong frame pushes earlier bits out, whatever the register held
	task automatic t_echo(input logic [31:0] ctrl);
		logic [47:0] pat;
		logic [47:0] got;
		pat = 48'ha5c3_96e1_0f3c;
		apb(1'b1, `OFF_CTRL, ctrl);
		serial_host_model_inst.send(pat, 48);
		idle(6);
		if (ctrl[1])
			got = serial_host_model_inst.pre_fall;
		else
			got = serial_host_model_inst.pre_rise;
		// Each bit comes back a full register length after it went in
		for (int i = 25; i < 48; i++) begin
			check("sdo", got[i], pat[72-i]);
		end
		check("oe after", pin_oe, 1'b0);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		gain_strap = 1'b0;
		reset_level_select = 1'b0;
		ref_divide_strap = 1'b0;
		load_strobe_n = 1'b1;
		ref_alarm = 1'b0;
		t_straps(1'b1, 1'b1, 1'b0);
		t_straps(1'b0, 1'b0, 1'b1);
		t_async();
		t_sync();
		t_fault();
		t_echo(32'h0);
		t_echo(32'h2);
		apb(1'b0, 8'h24, 32'h0);
		check("unmapped data", rd, 32'h0);
		check("unmapped err", err, 1'b1);
		conclude();
	end

	initial begin
		#4000000;
		error_cnt++;
		conclude();
	end
endmodule
`default_nettype wire
